/* rtl/slc_pkg.sv */
package slc_pkg;
   // Register offsets on the serial access port
   localparam logic [7:0] FAST_MODES_OFS  = 8'h00;
   localparam logic [7:0] AUX_ROUTE_OFS   = 8'h01;
   localparam logic [7:0] IN_TERM_OFS     = 8'h10;
   localparam logic [7:0] PULSE_LO_OFS    = 8'h11;
   localparam logic [7:0] PULSE_HI_OFS    = 8'h12;
   localparam logic [7:0] EQ_LO_OFS       = 8'h13;
   localparam logic [7:0] EQ_HI_OFS       = 8'h14;
   localparam logic [7:0] DRIVER_OFS      = 8'h20;
   // Values after reset
   localparam logic [7:0] FAST_MODES_RST  = 8'h40;
   localparam logic [7:0] AUX_ROUTE_RST   = 8'h40;
   localparam logic [7:0] IN_TERM_RST     = 8'h01;
   localparam logic [7:0] PULSE_RST       = 8'h00;
   localparam logic [7:0] EQ_RST          = 8'h00;
   localparam logic [7:0] DRIVER_RST      = 8'h03;
   // Writable bits; the rest read as zero
   localparam logic [7:0] MODES_MASK      = 8'h43;
   localparam logic [7:0] IN_TERM_MASK    = 8'h01;
   localparam logic [7:0] DRIVER_MASK     = 8'h0F;
   // Field positions
   localparam int         ENABLE_BIT      = 6;
   // Termination pulse length, derived to clock cycles
   localparam int         PULSE_MS        = 100;
   localparam int         CLK_HZ          = 10_000_000;
   localparam int         PULSE_CYCLES    = PULSE_MS * (CLK_HZ / 1000);

   // One access from the serial control front end
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } slc_access_t;

   // Strap pin levels
   typedef struct packed {
      logic       fast_enable;
      logic [1:0] source_select;
      logic       equaliser_level;
      logic [1:0] preemphasis_level;
      logic       output_termination;
      logic       output_current;
   } slc_strap_t;

   // Settings delivered to the analogue blocks
   typedef struct packed {
      logic        fast_channels_enable;
      logic [1:0]  fast_source_select;
      logic [3:0]  fast_route;
      logic [3:0]  aux_common_port;
      logic [15:0] input_term_connect;
      logic [15:0] equaliser_level_bits;
      logic [1:0]  output_preemphasis_level;
      logic        output_termination_enable;
      logic        output_current_select;
   } slc_cfg_t;
endpackage : slc_pkg

/* rtl/slc_config_regs.sv */
`timescale 1ns/1ps
// Contract
// - Aux select code picks source A to D
// - Input termination enable zero disconnects termination
// - Masked channel drops termination on source switch
// - Unmasked channel keeps termination across switches
// - Pulse mask order B, A, C3-0, D3-0
// - Equaliser bit selects low or high level
// - Equaliser bits share pulse mask order
// - Two-bit pre-emphasis field sets all outputs
// - Output termination bit switches all outputs
// - Output current bit selects 10/20 mA
// - Strap pins load the configuration registers
// - Straps govern only until first serial access
// - Fast source select routes; change is switch
// - Aux enable zero isolates all aux inputs
// - Fast enable zero puts channels in standby
module slc_config_regs #(
   parameter int PULSE_LEN = slc_pkg::PULSE_CYCLES // Pulse length, cycles
) (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   // Serial access port
   input  wire slc_pkg::slc_access_t i_acc,
   output logic [7:0]                o_acc_rdata,
   // Strap pins
   input  wire slc_pkg::slc_strap_t  i_strap,
   // Configuration in force
   output slc_pkg::slc_cfg_t         o_cfg,
   output logic                      o_strap_mode
);
   import slc_pkg::*;

   // Strap synchroniser stages and filtered value
   slc_strap_t  s1_q, s2_q, s3_q, strap_q;
   // Registers in force
   logic [7:0]  modes_q, aux_q, term_q, plo_q, phi_q, eqlo_q, eqhi_q, drv_q;
   logic        strap_mode_q;        // Straps still govern
   logic [1:0]  prev_src_q;          // Source seen last cycle
   logic [31:0] cnt_q;               // Remaining pulse cycles
   logic        src_change;          // Source switch event
   logic        wr;                  // Serial write this cycle
   logic        track;               // Registers follow straps
   logic [15:0] pmask, eq_bits;
   slc_cfg_t    cfg_q;

   // Masked store of a written byte
   function automatic logic [7:0] wr_hit(input logic [7:0] ofs,
                                         input logic [7:0] mask,
                                         input logic [7:0] cur);
      wr_hit = (wr && i_acc.addr == ofs) ? (i_acc.wdata & mask) : cur;
   endfunction : wr_hit

   assign wr    = i_acc.valid && i_acc.write;
   assign track = strap_mode_q && !i_acc.valid;
   assign pmask   = {phi_q, plo_q};
   assign eq_bits = {eqhi_q, eqlo_q};

   // Three-stage strap sync; only stage two reads stage one
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= i_strap;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a strap level once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         strap_q <= '0;
      end else if (s2_q == s3_q) begin
         strap_q <= s3_q;
      end
   end

   // Any serial access ends strap control until the next reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         strap_mode_q <= 1'b1;
      end else if (i_acc.valid) begin
         strap_mode_q <= 1'b0;
      end
   end

   // Register file: straps while tracking, serial writes afterwards
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         modes_q <= FAST_MODES_RST;
         aux_q   <= AUX_ROUTE_RST;
         term_q  <= IN_TERM_RST;
         plo_q   <= PULSE_RST;
         phi_q   <= PULSE_RST;
         eqlo_q  <= EQ_RST;
         eqhi_q  <= EQ_RST;
         drv_q   <= DRIVER_RST;
      end else if (track) begin
         // Parallel mode: aux on, termination on, no pulsing
         modes_q <= {1'b0, strap_q.fast_enable, 4'h0,
                     strap_q.source_select};
         aux_q   <= {2'h1, 4'h0, strap_q.source_select};
         term_q  <= IN_TERM_MASK;
         plo_q   <= 8'h00;
         phi_q   <= 8'h00;
         eqlo_q  <= {8{strap_q.equaliser_level}};
         eqhi_q  <= {8{strap_q.equaliser_level}};
         drv_q   <= {4'h0, strap_q.preemphasis_level,
                     strap_q.output_termination,
                     strap_q.output_current};
      end else begin
         modes_q <= wr_hit(FAST_MODES_OFS, MODES_MASK, modes_q);
         aux_q   <= wr_hit(AUX_ROUTE_OFS, MODES_MASK, aux_q);
         term_q  <= wr_hit(IN_TERM_OFS, IN_TERM_MASK, term_q);
         plo_q   <= wr_hit(PULSE_LO_OFS, 8'hFF, plo_q);
         phi_q   <= wr_hit(PULSE_HI_OFS, 8'hFF, phi_q);
         eqlo_q  <= wr_hit(EQ_LO_OFS, 8'hFF, eqlo_q);
         eqhi_q  <= wr_hit(EQ_HI_OFS, 8'hFF, eqhi_q);
         drv_q   <= wr_hit(DRIVER_OFS, DRIVER_MASK, drv_q);
      end
   end

   // Read data one cycle after the access; unmapped reads zero
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_acc_rdata <= 8'h00;
      end else if (i_acc.valid && !i_acc.write) begin
         unique case (i_acc.addr)
            FAST_MODES_OFS: o_acc_rdata <= modes_q;
            AUX_ROUTE_OFS:  o_acc_rdata <= aux_q;
            IN_TERM_OFS:    o_acc_rdata <= term_q;
            PULSE_LO_OFS:   o_acc_rdata <= plo_q;
            PULSE_HI_OFS:   o_acc_rdata <= phi_q;
            EQ_LO_OFS:      o_acc_rdata <= eqlo_q;
            EQ_HI_OFS:      o_acc_rdata <= eqhi_q;
            DRIVER_OFS:     o_acc_rdata <= drv_q;
            default:        o_acc_rdata <= 8'h00;
         endcase
      end
   end

   // A changed source field, from straps or serial, is a switch
   assign src_change = modes_q[1:0] != prev_src_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prev_src_q <= FAST_MODES_RST[1:0];
      end else begin
         prev_src_q <= modes_q[1:0];
      end
   end

   // Pulse counter; a new switch reloads it mid-interval
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else if (src_change) begin
         cnt_q <= 32'(PULSE_LEN);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 32'd1;
      end
   end

   // Outputs registered so the analogue side sees clean levels
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cfg_q <= '0;
      end else begin
         cfg_q.fast_channels_enable <= modes_q[ENABLE_BIT];
         cfg_q.fast_source_select   <= modes_q[1:0];
         cfg_q.fast_route <= modes_q[ENABLE_BIT] ?
                             4'(4'h1 << modes_q[1:0]) : 4'h0;
         cfg_q.aux_common_port <= aux_q[ENABLE_BIT] ?
                             4'(4'h1 << aux_q[1:0]) : 4'h0;
         // Bit order B0-3, A0-3, C3-0, D3-0 kept as stored
         cfg_q.input_term_connect <= {16{term_q[0]}} &
               ~(pmask & {16{cnt_q != '0}});
         cfg_q.equaliser_level_bits <= eq_bits;
         cfg_q.output_preemphasis_level  <= drv_q[3:2];
         cfg_q.output_termination_enable <= drv_q[1];
         cfg_q.output_current_select     <= drv_q[0];
      end
   end

   assign o_cfg        = cfg_q;
   assign o_strap_mode = strap_mode_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence switch_seen;
      src_change ##1 (cnt_q == 32'(PULSE_LEN));
   endsequence

   strap_ends_a: assert property (i_acc.valid |=> !strap_mode_q)
      else $error("strap mode survived a serial access");
   strap_eq_a: assert property (track |=>
      eqlo_q == {8{$past(strap_q.equaliser_level)}})
      else $error("equaliser did not follow strap");
   // Sampled reset in the antecedent: on the release edge the outputs
   // still hold their reset value while the registers do not
   aux_route_a: assert property (!i_rst |=> cfg_q.aux_common_port ==
      ($past(aux_q[ENABLE_BIT]) ? 4'(4'h1 << $past(aux_q[1:0])) : 4'h0))
      else $error("aux route wrong");
   term_off_a: assert property (!term_q[0] |=>
      cfg_q.input_term_connect == 16'h0000)
      else $error("termination on while disabled");
   pulse_drop_a: assert property (switch_seen ##0 pmask[0] && term_q[0]
      |=> !cfg_q.input_term_connect[0])
      else $error("masked channel not disconnected");
   keep_term_a: assert property (!i_rst && !pmask[5] && term_q[0] |=>
      cfg_q.input_term_connect[5])
      else $error("unmasked channel disconnected");
   restart_a: assert property (src_change && cnt_q > 32'd1 |=>
      cnt_q == 32'(PULSE_LEN))
      else $error("pulse did not restart");
   drive_out_a: assert property (!i_rst |=>
      cfg_q.output_preemphasis_level == $past(drv_q[3:2]) &&
      cfg_q.output_current_select == $past(drv_q[0]))
      else $error("driver settings not applied");
   read_back_a: assert property (i_acc.valid && !i_acc.write &&
      i_acc.addr == EQ_HI_OFS |=> o_acc_rdata == $past(eqhi_q))
      else $error("readback differs from value in force");
endmodule : slc_config_regs

/* verif/slc_strap_board.sv */
`timescale 1ns/1ps
module slc_strap_board (
   // Chosen levels
   input  wire slc_pkg::slc_strap_t i_level,
   // Pins as the device sees them
   output slc_pkg::slc_strap_t      o_pins
);
   import slc_pkg::*;
   // Board ties every pin hard to supply or ground, never floats
   assign o_pins = i_level;
endmodule : slc_strap_board

/* verif/switch_link_config_regs_test.sv */
`timescale 1ns/1ps
module switch_link_config_regs_test;
   import slc_pkg::*;
   localparam int PLEN = 20;  // Short pulse keeps the run brief
   logic        i_clk;        // Bench clock
   logic        i_rst;        // Synchronous reset
   slc_access_t acc;          // Register access
   slc_strap_t  lvl;          // Strap levels
   slc_strap_t  pins;         // Strap pins
   logic [7:0]  rdata;        // Read data
   slc_cfg_t    cfg;          // Settings in force
   logic        strap_mode;   // Straps govern
   logic [7:0]  rd, d, e, f;  // Read result and random bytes
   logic [15:0] q;            // Sixteen-bit mask value
   int          error_cnt;
   int          checks;

   slc_strap_board u_slc_strap_board (.i_level(lvl), .o_pins(pins));
   slc_config_regs #(.PULSE_LEN(PLEN)) u_slc_config_regs (
      .i_clk(i_clk), .i_rst(i_rst), .i_acc(acc), .o_acc_rdata(rdata),
      .i_strap(pins), .o_cfg(cfg), .o_strap_mode(strap_mode));

   // 100 ns clock
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // Verdict and end of run
   task automatic final_report;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   // Register byte compare
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   // Setting compare, narrow fields zero-extended
   task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_cfg

   // One access pulse; read data sampled once it has settled
   task automatic access(input logic wr, input logic [7:0] a, dt);
      @(posedge i_clk) acc <= '{1'b1, wr, a, dt};
      @(posedge i_clk) acc.valid <= 1'b0;
      @(posedge i_clk);
      #1 rd = rdata;
   endtask : access

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wait_cyc

   // Write, read back, reserved bits expected as zero
   task automatic wr_rd(input logic [7:0] a, dt, m);
      access(1'b1, a, dt);
      access(1'b0, a, 8'h00);
      chk_reg(rd, dt & m);
   endtask : wr_rd

   // Expected one-hot source, A in bit 0, zero when disabled
   function automatic logic [3:0] hot(input logic en, input logic [1:0] c);
      return en ? (4'h1 << c) : 4'h0;
   endfunction : hot

   // Watchdog: a hang counts as a mismatch
   initial begin
      #2_000_000;
      error_cnt++;
      final_report;
   end

   initial begin
      void'($urandom(32'h4e92));
      error_cnt = 0;
      checks = 0;
      i_rst <= 1'b1;
      acc <= '0;
      lvl <= '{1'b1, 2'h2, 1'b1, 2'h1, 1'b0, 1'b1};
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      wait_cyc(10);
      // Straps govern straight after reset
      chk_cfg(strap_mode, 16'h0001);
      chk_cfg(cfg.fast_route, hot(1'b1, 2'h2));
      chk_cfg(cfg.aux_common_port, hot(1'b1, 2'h2));
      chk_cfg(cfg.equaliser_level_bits, 16'hFFFF);
      chk_cfg(cfg.input_term_connect, 16'hFFFF);
      chk_cfg({cfg.output_preemphasis_level, cfg.output_termination_enable,
               cfg.output_current_select}, 16'h0005);
      // A read ends strap mode and shows the value in force
      access(1'b0, DRIVER_OFS, 8'h00);
      chk_reg(rd, 8'h05);
      @(posedge i_clk) lvl <= '0;
      wait_cyc(10);
      chk_cfg(strap_mode, 16'h0000);
      chk_cfg(cfg.fast_route, hot(1'b1, 2'h2));
      // Every select code, random payload in the other bits
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         d[ENABLE_BIT] = 1'b1;
         d[1:0] = 2'(i);
         e = 8'($urandom);
         e[ENABLE_BIT] = 1'b1;
         e[1:0] = 2'(3 - i);
         f = 8'($urandom);
         q = 16'($urandom);
         wr_rd(FAST_MODES_OFS, d, MODES_MASK);
         wr_rd(AUX_ROUTE_OFS, e, MODES_MASK);
         wr_rd(DRIVER_OFS, f, DRIVER_MASK);
         wr_rd(EQ_LO_OFS, q[7:0], 8'hFF);
         wr_rd(EQ_HI_OFS, q[15:8], 8'hFF);
         wait_cyc(PLEN + 5);
         chk_cfg(cfg.fast_route, hot(1'b1, 2'(i)));
         chk_cfg(16'(cfg.fast_source_select), 16'(i));
         chk_cfg(cfg.aux_common_port, hot(1'b1, 2'(3 - i)));
         chk_cfg(cfg.equaliser_level_bits, q);
         chk_cfg({cfg.output_preemphasis_level, cfg.output_termination_enable,
                  cfg.output_current_select}, f[3:0]);
      end
      wr_rd(8'h30, 8'hFF, 8'h00);
      wr_rd(IN_TERM_OFS, 8'hFF, IN_TERM_MASK);
      // Pulse on a switch, restarted by a second switch
      q = 16'h81A5;
      wr_rd(PULSE_LO_OFS, q[7:0], 8'hFF);
      wr_rd(PULSE_HI_OFS, q[15:8], 8'hFF);
      access(1'b1, FAST_MODES_OFS, 8'h41);
      wait_cyc(2);
      chk_cfg(cfg.input_term_connect, ~q);
      wait_cyc(8);
      access(1'b1, FAST_MODES_OFS, 8'h42);
      wait_cyc(14);
      chk_cfg(cfg.input_term_connect, ~q);
      wait_cyc(PLEN);
      chk_cfg(cfg.input_term_connect, 16'hFFFF);
      // Enables off
      access(1'b1, IN_TERM_OFS, 8'h00);
      access(1'b1, FAST_MODES_OFS, 8'h02);
      access(1'b1, AUX_ROUTE_OFS, 8'h01);
      wait_cyc(PLEN + 3);
      chk_cfg(cfg.input_term_connect, 16'h0000);
      chk_cfg(cfg.fast_route, 16'h0000);
      chk_cfg(cfg.fast_channels_enable, 16'h0000);
      chk_cfg(cfg.aux_common_port, 16'h0000);
      // Second reset: other strap levels govern again until a serial access
      @(posedge i_clk) i_rst <= 1'b1;
      lvl <= '{1'b0, 2'h1, 1'b0, 2'h2, 1'b1, 1'b0};
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      wait_cyc(10);
      chk_cfg(16'(strap_mode), 16'h0001);
      chk_cfg(16'(cfg.fast_route), 16'h0000);
      chk_cfg(16'(cfg.fast_source_select), 16'h0001);
      chk_cfg(16'(cfg.aux_common_port), 16'(hot(1'b1, 2'h1)));
      chk_cfg(cfg.equaliser_level_bits, 16'h0000);
      chk_cfg(cfg.input_term_connect, 16'hFFFF);
      chk_cfg(16'({cfg.output_preemphasis_level,
                   cfg.output_termination_enable,
                   cfg.output_current_select}), 16'h000A);
      // A first access that writes still lands and ends strap mode
      access(1'b1, EQ_LO_OFS, 8'h3C);
      access(1'b0, EQ_LO_OFS, 8'h00);
      chk_reg(rd, 8'h3C);
      access(1'b0, EQ_HI_OFS, 8'h00);
      chk_reg(rd, 8'h00);
      chk_cfg(16'(strap_mode), 16'h0000);
      final_report;
   end
endmodule : switch_link_config_regs_test
